/* File: iam_map.svh */
// Constants for the address-match and interrupt block of the two-wire bus
// Assumes inclusion by bare name from the design module only
`ifndef IAM_MAP_SVH
`define IAM_MAP_SVH

// Address byte layout
`define IAM_ADDR_MSB 7
`define IAM_ADDR_LSB 1
`define IAM_RW_POS   0
`define IAM_GC_ADDR  7'h00

// Bit counts within one byte frame
`define IAM_CNT_RST  4'h0
`define IAM_CNT_ONE  4'h1
`define IAM_CNT_BYTE 4'h8
`define IAM_CNT_ACK  4'h9

// Reset values
`define IAM_BYTE_RST 8'h00
`define IAM_BIT_RST  1'b0

`endif

/* File: iam_pkg.sv */
// Types shared by the address-match and interrupt block
// Assumes no other package is needed
package iam_pkg;

  // Frame tracking states
  typedef enum logic [2:0] {
    IAM_IDLE = 3'b000,
    IAM_ADDR = 3'b001,
    IAM_RECV = 3'b010,
    IAM_SEND = 3'b011,
    IAM_SKIP = 3'b100
  } iam_state_t;

  // Software configuration bits
  typedef struct packed {
    logic       moduleEnable;
    logic       general_call_match_enable;
    logic       bus_irq_enable;
    logic [6:0] slaveAddr;
  } iam_cfg_t;

  // Status flags seen by software
  typedef struct packed {
    logic bus_irq_flag;
    logic transfer_complete_flag;
    logic addressed_as_slave_flag;
    logic arbitration_lost_flag;
    logic slave_read_write_status;
  } iam_stat_t;

endpackage : iam_pkg

/* File: iam_addr_match_irq.sv */
// Address match, general call and interrupt logic of a two-wire bus controller
// Assumes the byte shifter and master sequencer sit outside on mclk,
// and that sclClk is the bus clock pin, which stops between frames.
// Function
// R01: General call recognised in both address formats; the code decodes 7-bit addresses only
// R02: Enabled general call matches besides own address
// R03: General call answered as receiver, flag after address
// R04: Software reads data zero to spot general call
// R05: Disabled general call gets no acknowledge, data ignored
// R06: Disabled after reset, no reset output path
// R07: Single interrupt output from flag and enable
// R08: Interrupt flag cleared only by writing one
// R09: Flag set by byte done, match, arbitration loss
// R10: Software reads status flags to find cause
// R11: Transfer complete set at ninth clock falling edge
// R12: Addressed flag on own match or enabled call
// R13: Software sets direction from read/write status
// R14: Contention resolved by bitwise data arbitration
// R15: Arbitration loss sets its flag and interrupt
// R16: Address last bit gives transfer direction
// R17: Matching slave holds data low at ninth clock
// R18: Lost arbitration falls back to slave decoding
// R19: Data register holds last received byte
// R20: Interrupt is flag AND enable
module iam_addr_match_irq
  import iam_pkg::*;
(
  // Clock, reset and freeze
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       clkEn,
  // Bus pins; sclClk is the link clock
  input  wire logic       sclClk,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  // Software controls
  input  wire iam_cfg_t   cfg,
  input  wire logic       irqFlagClr,
  input  wire logic       arbLostClr,
  input  wire logic       ctrlWr,
  // Master sequencer state
  input  wire logic       masterActive,
  input  wire logic       masterSdaLow,
  // Status and data
  output iam_stat_t       status,
  output logic [7:0]      bus_data_register,
  output logic            busIrq
);

`include "iam_map.svh"

  // Address decode: bit 1 own match, bit 0 general call
  function automatic logic [1:0] addrDecode(input logic [7:0] b, input iam_cfg_t c);
    logic [6:0] a;
    a = b[`IAM_ADDR_MSB:`IAM_ADDR_LSB];
    addrDecode = {a == c.slaveAddr, a == `IAM_GC_ADDR}; // R01
  endfunction : addrDecode

  // Link domain
  logic [7:0] linkShift_r;
  logic       linkTgl_r;

  // Synchronisers
  logic tglMeta_r;
  logic tglSync_r;
  logic tglSeen_r;
  logic sclMeta_r;
  logic sclSync_r;
  logic sclPrev_r;
  logic sdaMeta_r;
  logic sdaSync_r;
  logic sdaPrev_r;

  // Frame tracking
  iam_state_t state_r;
  iam_state_t state_nxt;
  logic [3:0] bitCnt_r;
  logic [3:0] cntInc;
  logic       hit_r;
  logic       ackPend_r;

  // Flags and outputs
  logic tcf_r;
  logic addressed_as_slave_flag_r;
  logic arbitration_lost_flag_r;
  logic srw_r;
  logic irqFlag_r;
  logic irqFlag_nxt;
  logic sdaOe_r;
  logic sdaOut_r;
  logic busIrq_r;
  logic [7:0] data_r;

  // Events
  logic       riseEv;
  logic       fallEv;
  logic       startEv;
  logic       stopEv;
  logic       byteDone;
  logic       ackDone;
  logic [1:0] dec;
  logic       hitNow;
  logic       selected;
  logic       tcfSet;
  logic       iaasSet;
  logic       arblSet;

  // Samples SDA on each rising SCL; toggle marks each new bit
  always_ff @(posedge sclClk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      linkShift_r <= `IAM_BYTE_RST;
      linkTgl_r   <= `IAM_BIT_RST;
    end
    else
    begin
      linkShift_r <= {linkShift_r[6:0], sdaIn};
      linkTgl_r   <= ~linkTgl_r;
    end
  end

  // Two-flop synchronisers; the shift word is read only after the toggle
  // arrives, when SCL is high and the word cannot move
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tglMeta_r <= `IAM_BIT_RST;
      tglSync_r <= `IAM_BIT_RST;
      tglSeen_r <= `IAM_BIT_RST;
      sclMeta_r <= 1'b1;
      sclSync_r <= 1'b1;
      sclPrev_r <= 1'b1;
      sdaMeta_r <= 1'b1;
      sdaSync_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end
    else if (clkEn)
    begin
      tglMeta_r <= linkTgl_r;
      tglSync_r <= tglMeta_r;
      tglSeen_r <= tglSync_r;
      sclMeta_r <= sclIn;
      sclSync_r <= sclMeta_r;
      sclPrev_r <= sclSync_r;
      sdaMeta_r <= sdaIn;
      sdaSync_r <= sdaMeta_r;
      sdaPrev_r <= sdaSync_r;
    end
  end

  // Bus events as seen on mclk
  assign riseEv   = tglSync_r ^ tglSeen_r;
  assign fallEv   = sclPrev_r & ~sclSync_r;
  assign startEv  = sclSync_r & sclPrev_r & sdaPrev_r & ~sdaSync_r;
  assign stopEv   = sclSync_r & sclPrev_r & ~sdaPrev_r & sdaSync_r;
  assign cntInc   = bitCnt_r + `IAM_CNT_ONE;
  assign byteDone = riseEv && (cntInc == `IAM_CNT_BYTE);
  assign ackDone  = fallEv && (bitCnt_r == `IAM_CNT_ACK);

  // Own address always; general call only when enabled
  assign dec    = addrDecode(linkShift_r, cfg);
  assign hitNow = dec[1] | (dec[0] & cfg.general_call_match_enable                // R02
                  & ~linkShift_r[`IAM_RW_POS]);                                  // R03
  assign selected = (state_r == IAM_RECV) || (state_r == IAM_SEND)
                    || ((state_r == IAM_ADDR) && hit_r);

  // Bit counter per byte, cleared by start and after the ack bit
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bitCnt_r <= `IAM_CNT_RST;
    end
    else if (clkEn)
    begin
      if (startEv || stopEv || !cfg.moduleEnable)
      begin
        bitCnt_r <= `IAM_CNT_RST;
      end
      else if (ackDone)
      begin
        bitCnt_r <= `IAM_CNT_RST;
      end
      else if (riseEv && (bitCnt_r != `IAM_CNT_ACK))
      begin
        bitCnt_r <= cntInc;
      end
    end
  end

  // Frame state selection; a lost master keeps decoding as slave
  always_comb
  begin
    state_nxt = state_r;
    if (!cfg.moduleEnable || stopEv)
    begin
      state_nxt = IAM_IDLE;                                                   // R06
    end
    else if (startEv)
    begin
      state_nxt = IAM_ADDR;                                                   // R18
    end
    else if (ackDone)
    begin
      case (state_r)
        IAM_ADDR:
        begin
          if (!hit_r)
          begin
            state_nxt = IAM_SKIP;                                             // R05
          end
          else if (srw_r)
          begin
            state_nxt = IAM_SEND;                                             // R16
          end
          else
          begin
            state_nxt = IAM_RECV;                                             // R03
          end
        end
        IAM_IDLE: state_nxt = IAM_IDLE;
        IAM_RECV: state_nxt = IAM_RECV;
        IAM_SEND: state_nxt = IAM_SEND;
        IAM_SKIP: state_nxt = IAM_SKIP;
        default:  state_nxt = IAM_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= IAM_IDLE;
    end
    else if (clkEn)
    begin
      state_r <= state_nxt;
    end
  end

  // Address match and direction latched at the eighth bit
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hit_r <= `IAM_BIT_RST;
      srw_r <= `IAM_BIT_RST;
    end
    else if (clkEn)
    begin
      if (startEv)
      begin
        hit_r <= `IAM_BIT_RST;
      end
      else if (byteDone && (state_r == IAM_ADDR))
      begin
        hit_r <= hitNow;                                                      // R12
        if (hitNow)
        begin
          srw_r <= linkShift_r[`IAM_RW_POS];                                  // R16
        end
      end
    end
  end

  // Acknowledge wanted: matched address or accepted receive data
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ackPend_r <= `IAM_BIT_RST;
    end
    else if (clkEn)
    begin
      if (startEv || stopEv || ackDone)
      begin
        ackPend_r <= `IAM_BIT_RST;
      end
      else if (byteDone)
      begin
        ackPend_r <= ((state_r == IAM_ADDR) && hitNow) || (state_r == IAM_RECV); // R05
      end
    end
  end

  // Open-drain drive: pull low from the eighth fall to the ninth fall
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sdaOe_r  <= `IAM_BIT_RST;
      sdaOut_r <= `IAM_BIT_RST;
    end
    else if (clkEn)
    begin
      sdaOut_r <= `IAM_BIT_RST;
      if (!cfg.moduleEnable || startEv || stopEv || ackDone)
      begin
        sdaOe_r <= `IAM_BIT_RST;
      end
      else if (fallEv && (bitCnt_r == `IAM_CNT_BYTE) && ackPend_r)
      begin
        sdaOe_r <= 1'b1;                                                      // R17
      end
    end
  end

  // Last received byte; the address byte is kept so a call reads zero
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      data_r <= `IAM_BYTE_RST;
    end
    else if (clkEn && byteDone)
    begin
      if (masterActive || (state_r == IAM_RECV))
      begin
        data_r <= linkShift_r;                                                // R19
      end
      else if ((state_r == IAM_ADDR) && hitNow)
      begin
        data_r <= linkShift_r;                                                // R04
      end
    end
  end

  // Flag set terms
  assign tcfSet  = ackDone && (masterActive || selected);                     // R11
  assign iaasSet = ackDone && (state_r == IAM_ADDR) && hit_r;                 // R03
  // Released line read back low means another master won
  assign arblSet = riseEv && masterActive && !masterSdaLow
                   && !linkShift_r[0];                                        // R14

  // Transfer complete clears as the next byte begins
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tcf_r <= `IAM_BIT_RST;
    end
    else if (clkEn)
    begin
      if (tcfSet)
      begin
        tcf_r <= 1'b1;                                                        // R11
      end
      else if (riseEv && (bitCnt_r == `IAM_CNT_RST))
      begin
        tcf_r <= `IAM_BIT_RST;
      end
    end
  end

  // Addressed flag; a control write clears it, a new match wins
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      addressed_as_slave_flag_r <= `IAM_BIT_RST;
    end
    else if (clkEn)
    begin
      if (iaasSet)
      begin
        addressed_as_slave_flag_r <= 1'b1;                                                       // R12
      end
      else if (ctrlWr)
      begin
        addressed_as_slave_flag_r <= `IAM_BIT_RST;
      end
    end
  end

  // Arbitration lost; sticky until written with one
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      arbitration_lost_flag_r <= `IAM_BIT_RST;
    end
    else if (clkEn)
    begin
      if (arblSet)
      begin
        arbitration_lost_flag_r <= 1'b1;                                                       // R15
      end
      else if (arbLostClr)
      begin
        arbitration_lost_flag_r <= `IAM_BIT_RST;
      end
    end
  end

  // Interrupt flag: any cause sets, only a one-write clears, set wins
  always_comb
  begin
    irqFlag_nxt = irqFlag_r;
    if (tcfSet || iaasSet || arblSet)
    begin
      irqFlag_nxt = 1'b1;                                                     // R09
    end
    else if (irqFlagClr)
    begin
      irqFlag_nxt = `IAM_BIT_RST;                                             // R08
    end
  end

  // Interrupt output registered from next flag so it tracks the flag
  // without a cycle of lag; the enable is seen one cycle late
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irqFlag_r <= `IAM_BIT_RST;
      busIrq_r  <= `IAM_BIT_RST;
    end
    else if (clkEn)
    begin
      irqFlag_r <= irqFlag_nxt;
      busIrq_r  <= irqFlag_nxt & cfg.bus_irq_enable;                          // R20
    end
  end

  // Outputs; no reset request leaves this block
  assign sdaOe             = sdaOe_r;
  assign sdaOut            = sdaOut_r;
  assign bus_data_register = data_r;
  assign busIrq            = busIrq_r;                                        // R07
  assign status = '{bus_irq_flag:            irqFlag_r,
                    transfer_complete_flag:  tcf_r,
                    addressed_as_slave_flag: addressed_as_slave_flag_r,
                    arbitration_lost_flag:   arbitration_lost_flag_r,
                    slave_read_write_status: srw_r};                          // R13

endmodule : iam_addr_match_irq

/* File: iam_chk.sv */
// Port assertions for the address-match and interrupt block
// Assumes binding to iam_addr_match_irq; all checks on mclk
module iam_chk
  import iam_pkg::*;
(
  // Clock and reset
  input wire logic      mclk,
  input wire logic      arst_n,
  // Software controls
  input wire iam_cfg_t  cfg,
  input wire logic      irqFlagClr,
  input wire logic      arbLostClr,
  input wire logic      ctrlWr,
  // Observed outputs
  input wire logic      sdaOut,
  input wire logic      sdaOe,
  input wire iam_stat_t status,
  input wire logic      busIrq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  // Mask is registered, so it acts one cycle late
  chk_irq_gate: assert property (
    busIrq == ($past(cfg.bus_irq_enable) && status.bus_irq_flag))
    else $error("interrupt output not flag and enable");
  chk_irq_clear: assert property (
    $fell(status.bus_irq_flag) |-> $past(irqFlagClr))
    else $error("interrupt flag dropped without clear");
  chk_irq_cause: assert property (
    $rose(status.bus_irq_flag) |-> status.transfer_complete_flag
      || status.addressed_as_slave_flag || status.arbitration_lost_flag)
    else $error("interrupt flag rose without cause");
  chk_arb_irq: assert property (
    $rose(status.arbitration_lost_flag) |-> status.bus_irq_flag)
    else $error("arbitration loss without interrupt flag");
  chk_arb_clear: assert property (
    $fell(status.arbitration_lost_flag) |-> $past(arbLostClr))
    else $error("arbitration flag dropped without clear");
  chk_addr_irq: assert property (
    $rose(status.addressed_as_slave_flag) |-> status.bus_irq_flag
      && status.transfer_complete_flag)
    else $error("address match without byte and interrupt flags");
  chk_addr_clear: assert property (
    $fell(status.addressed_as_slave_flag) |-> $past(ctrlWr))
    else $error("addressed flag dropped without control write");
  chk_ack_low: assert property (
    sdaOe |-> !sdaOut)
    else $error("data line driven high");
  // Acknowledge held for at least eight mclk cycles, never a glitch
  chk_ack_hold: assert property (
    $rose(sdaOe) |-> sdaOe [*8])
    else $error("acknowledge too short");
  chk_off_quiet: assert property (
    !cfg.moduleEnable [*3] |-> !sdaOe)
    else $error("disabled block drives data line");
endmodule : iam_chk

bind iam_addr_match_irq iam_chk chk_u (
  .mclk(mclk), .arst_n(arst_n), .cfg(cfg), .irqFlagClr(irqFlagClr),
  .arbLostClr(arbLostClr), .ctrlWr(ctrlWr), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .status(status), .busIrq(busIrq)
);

/* File: iam_bus_model.sv */
// Behavioural master on the two-wire bus, paced by mclk
// Assumes a pull-up on SDA; SCL rests high between frames
module iam_bus_model
(
  // Pacing clock
  input  wire logic mclk,
  // Lines; sdaRel high lets the pull-up win
  output logic      scl,
  output logic      sdaRel,
  input  wire logic sdaLine
);
  timeunit 1ns;
  timeprecision 1ps;
  // SCL half period in mclk cycles, slow enough for the synchronisers
  localparam int HALF = 10;

  initial
  begin
    scl = 1'b1;
    sdaRel = 1'b1;
  end

  task automatic hold;
    repeat (HALF) @(posedge mclk);
  endtask : hold

  // Data falls while SCL high
  task automatic startCond;
    sdaRel <= 1'b0;
    hold;
    scl <= 1'b0;
    hold;
  endtask : startCond

  // MSB first, data changes only while SCL low
  task automatic sendByte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sdaRel <= b[i];
      hold;
      scl <= 1'b1;
      hold;
      scl <= 1'b0;
    end
    sdaRel <= 1'b1;
    hold;
    scl <= 1'b1;
    ack = (sdaLine === 1'b0);
    hold;
    scl <= 1'b0;
  endtask : sendByte

  // Data rises while SCL high, then both rest released
  task automatic stopCond;
    sdaRel <= 1'b0;
    hold;
    scl <= 1'b1;
    hold;
    sdaRel <= 1'b1;
    hold;
  endtask : stopCond
endmodule : iam_bus_model

/* File: tb_top.sv */
// Self-checking bench for the address-match and interrupt block
// Assumes iam_bus_model as the other master; SCL doubles as link clock
module tb_top import iam_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk, arst_n, clkEn, irqFlagClr, arbLostClr, ctrlWr;
  logic       masterActive, masterSdaLow, sdaOut, sdaOe, busIrq;
  logic       scl, sdaRel, sdaLine;
  iam_cfg_t   cfg;
  iam_stat_t  status;
  logic [7:0] busData;
  int         errCount, nChecks, cycles;

  // Wired-AND data line with pull-up
  assign sdaLine = sdaRel & ~(sdaOe & ~sdaOut);

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  iam_addr_match_irq dut_u (
    .mclk(mclk), .arst_n(arst_n), .clkEn(clkEn), .sclClk(scl),
    .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .cfg(cfg), .irqFlagClr(irqFlagClr), .arbLostClr(arbLostClr),
    .ctrlWr(ctrlWr), .masterActive(masterActive),
    .masterSdaLow(masterSdaLow), .status(status),
    .bus_data_register(busData), .busIrq(busIrq)
  );
  iam_bus_model mst_u (.mclk(mclk), .scl(scl), .sdaRel(sdaRel), .sdaLine(sdaLine));

  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    nChecks++;
    if (got !== ex)
    begin
      errCount++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic settle;
    repeat (6) @(posedge mclk);
    #1;
  endtask : settle

  // All three write-one clears at once, then every flag but transfer complete and read/write status must read zero
  task automatic clrAll;
    @(posedge mclk);
    irqFlagClr <= 1'b1;
    arbLostClr <= 1'b1;
    ctrlWr <= 1'b1;
    @(posedge mclk);
    irqFlagClr <= 1'b0;
    arbLostClr <= 1'b0;
    ctrlWr <= 1'b0;
    #1;
    chk("flags cleared", 8'h00, {4'h0, busIrq, status[4], status[2:1]});
  endtask : clrAll

  // Address byte, one data byte, stop; m says the block should answer
  task automatic frame(input string nm, input logic [7:0] a, d, input logic m);
    logic ackA;
    logic ackD;
    clrAll;
    mst_u.startCond;
    mst_u.sendByte(a, ackA);
    settle;
    chk({nm, " ack"}, {7'h00, m}, {7'h00, ackA});
    chk({nm, " matched"}, {7'h00, m}, {7'h00, status.addressed_as_slave_flag});
    chk({nm, " irq flag"}, {7'h00, m}, {7'h00, status.bus_irq_flag});
    chk({nm, " irq"}, {7'h00, m}, {7'h00, busIrq});
    chk({nm, " done"}, {7'h00, m}, {7'h00, status.transfer_complete_flag});
    if (m) chk({nm, " addr byte"}, a, busData);
    if (m) chk({nm, " rw"}, {7'h00, a[0]}, {7'h00, status.slave_read_write_status});
    mst_u.sendByte(d, ackD);
    settle;
    chk({nm, " data ack"}, {7'h00, m & ~a[0]}, {7'h00, ackD});
    if (m && !a[0]) chk({nm, " data"}, d, busData);
    mst_u.stopCond;
    $display("test %s done", nm);
  endtask : frame

  // Flag held while the mask hides the output
  task automatic maskTest;
    cfg.bus_irq_enable <= 1'b0;
    settle;
    chk("masked irq", 8'h00, {7'h00, busIrq});
    chk("masked flag", 8'h01, {7'h00, status.bus_irq_flag});
    cfg.bus_irq_enable <= 1'b1;
    settle;
    chk("unmasked irq", 8'h01, {7'h00, busIrq});
    $display("test mask done");
  endtask : maskTest

  // Clock enable low freezes the flag even against a clear strobe
  task automatic freezeTest;
    @(posedge mclk);
    clkEn <= 1'b0;
    irqFlagClr <= 1'b1;
    @(posedge mclk);
    irqFlagClr <= 1'b0;
    settle;
    chk("frozen flag", 8'h01, {7'h00, status.bus_irq_flag});
    @(posedge mclk);
    clkEn <= 1'b1;
    settle;
    chk("thawed flag", 8'h01, {7'h00, status.bus_irq_flag});
    $display("test freeze done");
  endtask : freezeTest

  // Another master wins on a zero bit; decoding carries on
  task automatic arbTest;
    masterActive <= 1'b1;
    frame("arb", 8'hB4, 8'h3C, 1'b1);
    chk("arb lost", 8'h01, {7'h00, status.arbitration_lost_flag});
    masterActive <= 1'b0;
    clrAll;
    $display("test arb done");
  endtask : arbTest

  task automatic completeRun;
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : completeRun

  // Hang guard, well above the few thousand cycles the frames take
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errCount++;
      completeRun;
    end
  end

  initial
  begin
    arst_n = 1'b0;
    clkEn = 1'b1;
    irqFlagClr = 1'b0;
    arbLostClr = 1'b0;
    ctrlWr = 1'b0;
    masterActive = 1'b0;
    masterSdaLow = 1'b0;
    cfg = {1'b0, 1'b0, 1'b1, 7'h5A};
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    settle;
    chk("reset outputs", 8'h00, {1'h0, status, sdaOe, busIrq});
    frame("off", 8'hB4, 8'h3C, 1'b0);
    cfg.moduleEnable <= 1'b1;
    frame("own", 8'hB4, 8'h3C, 1'b1);
    maskTest;
    freezeTest;
    frame("miss", 8'hB6, 8'h3C, 1'b0);
    frame("read", 8'hB5, 8'hFF, 1'b1);
    frame("gc off", 8'h00, 8'h77, 1'b0);
    cfg.general_call_match_enable <= 1'b1;
    frame("gc on", 8'h00, 8'h77, 1'b1);
    arbTest;
    completeRun;
  end
endmodule : tb_top
